// *** src/dag_consts.svh ***
// Register offsets, field positions, reset values and steps of the data address generator
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH

`define DAG_OFF_CTRL        8'h00
`define DAG_OFF_BOUNDS      8'h04
`define DAG_OFF_X_ADDR      8'h28
`define DAG_OFF_Y_ADDR      8'h2C
`define DAG_OFF_MAIN_ADDR   8'h30

`define DAG_CTRL_X_WRAP     0
`define DAG_CTRL_Y_WRAP     1
`define DAG_CTRL_RST        2'h0
`define DAG_BOUNDS_RST      32'h0000_0000
`define DAG_GPR_RST         32'h0000_0000
`define DAG_WORD_RST        32'h0000_0000

`define DAG_GPR_LO          2
`define DAG_GPR_HI          9
`define DAG_X_BASE          4'h4
`define DAG_Y_BASE          4'h6
`define DAG_S_BASE          4'h2
`define DAG_X_INDEX         8
`define DAG_Y_INDEX         9
`define DAG_S_INDEX         8

`define DAG_STEP_WORD       32'h0000_0002
`define DAG_STEP_LONG       32'h0000_0004
`define DAG_ADDR_MASK       16'hFFFE

`endif

// *** src/dag_pkg.sv ***
// Types shared by the data address generator modules
package dag_pkg;

  typedef enum logic [1:0] {
    DAG_XY_NOP,
    DAG_XY_INC,
    DAG_XY_IDX
  } dag_xy_mode_e;

  typedef enum logic [1:0] {
    DAG_S_NOP,
    DAG_S_INC,
    DAG_S_IDX,
    DAG_S_DEC
  } dag_s_mode_e;

endpackage

// *** src/dag_single_update.sv ***
// Access address and update of a single-transfer pointer
`timescale 1ns/1ps
`include "dag_consts.svh"

module dag_single_update (
  input  wire logic [31:0]         ptr,
  input  wire logic [31:0]         index,
  input  wire dag_pkg::dag_s_mode_e mode,
  input  wire logic                is_long,
  output logic      [31:0]         access_addr,
  output logic      [31:0]         next_ptr
);

  logic [31:0] step;
  logic [31:0] dec;

  assign step = is_long ? `DAG_STEP_LONG : `DAG_STEP_WORD;
  assign dec  = ptr - step;
  // Decrement updates first and accesses the reduced address
  assign access_addr = (mode == dag_pkg::DAG_S_DEC) ? dec : ptr;

  always_comb begin
    unique case (mode)
      dag_pkg::DAG_S_NOP: next_ptr = ptr;
      dag_pkg::DAG_S_INC: next_ptr = ptr + step;
      dag_pkg::DAG_S_IDX: next_ptr = ptr + index;
      dag_pkg::DAG_S_DEC: next_ptr = dec;
    endcase
  end

endmodule

// *** src/dag_top.sv ***
// Data address generator for paired X/Y and single data transfers
`timescale 1ns/1ps
`include "dag_consts.svh"

module dag_top (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  xy_valid,
  input  wire logic                  x_en,
  input  wire logic                  x_sel,
  input  wire dag_pkg::dag_xy_mode_e x_mode,
  input  wire logic                  y_en,
  input  wire logic                  y_sel,
  input  wire dag_pkg::dag_xy_mode_e y_mode,
  input  wire logic                  single_valid,
  input  wire logic [1:0]            single_sel,
  input  wire dag_pkg::dag_s_mode_e  single_mode,
  input  wire logic                  single_long,
  output logic                       single_ready,
  input  wire logic                  core_bus_grant,
  output logic      [15:0]           x_memory_address_bus,
  output logic                       x_req,
  output logic      [15:0]           y_memory_address_bus,
  output logic                       y_req,
  output logic      [31:0]           main_memory_address_bus,
  output logic                       main_req,
  output logic                       main_long
);

  logic [31:0] gpr_q [`DAG_GPR_LO:`DAG_GPR_HI];
  logic [31:0] gpr_d [`DAG_GPR_LO:`DAG_GPR_HI];
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [31:0] bounds_q;
  logic [31:0] bounds_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] x_addr_q;
  logic [15:0] y_addr_q;
  logic [31:0] main_addr_q;
  logic        x_req_q;
  logic        y_req_q;
  logic        main_req_q;
  logic        main_long_q;

  // Selection and decode
  wire         x_fire = xy_valid && x_en;
  wire         y_fire = xy_valid && y_en;
  // Paired transfers own their buses; the shared bus waits for grant
  // and yields in any cycle that xy_valid is high, even with neither x_en nor y_en set
  wire         s_fire = single_valid && single_ready;
  wire  [3:0]  x_tgt  = x_sel ? (`DAG_X_BASE + 4'h1) : `DAG_X_BASE;
  wire  [3:0]  y_tgt  = y_sel ? (`DAG_Y_BASE + 4'h1) : `DAG_Y_BASE;
  wire  [3:0]  s_tgt  = `DAG_S_BASE + {2'h0, single_sel};
  wire  [31:0] x_ptr  = x_sel ? gpr_q[5] : gpr_q[4];
  wire  [31:0] y_ptr  = y_sel ? gpr_q[7] : gpr_q[6];
  wire  [31:0] s_ptr  = gpr_q[s_tgt];
  // Only one pointer may wrap; Y takes it when both are enabled
  wire         y_wrap = ctrl_q[`DAG_CTRL_Y_WRAP];
  wire         x_wrap = ctrl_q[`DAG_CTRL_X_WRAP] && !y_wrap;
  wire  [31:0] x_next;
  wire  [31:0] y_next;
  wire  [31:0] s_next;
  wire  [31:0] s_access;
  wire         x_wrapped;
  wire         y_wrapped;

  // Register file access; register number equals word offset
  wire         gpr_hit = (reg_addr[7:6] == 2'h0) && (reg_addr[1:0] == 2'h0)
                         && (reg_addr[5:2] >= 4'h2) && (reg_addr[5:2] <= 4'h9);
  wire         ctrl_wr   = reg_wr && (reg_addr == `DAG_OFF_CTRL);
  wire         bounds_wr = reg_wr && (reg_addr == `DAG_OFF_BOUNDS);

  assign single_ready = core_bus_grant && !xy_valid;

  dag_xy_update u_x_update (
    .ptr        (x_ptr),
    .index      (gpr_q[`DAG_X_INDEX]),
    .mode       (x_mode),
    .wrap_en    (x_wrap),
    .keep_upper (1'b0),
    .bounds     (bounds_q),
    .next_ptr   (x_next),
    .wrapped    (x_wrapped)
  );

  dag_xy_update u_y_update (
    .ptr        (y_ptr),
    .index      (gpr_q[`DAG_Y_INDEX]),
    .mode       (y_mode),
    .wrap_en    (y_wrap),
    .keep_upper (1'b1),
    .bounds     (bounds_q),
    .next_ptr   (y_next),
    .wrapped    (y_wrapped)
  );

  // No bounds reach the single path, so it can never wrap
  dag_single_update u_s_update (
    .ptr         (s_ptr),
    .index       (gpr_q[`DAG_S_INDEX]),
    .mode        (single_mode),
    .is_long     (single_long),
    .access_addr (s_access),
    .next_ptr    (s_next)
  );

  // A software write wins over a pointer update to the same register
  generate
    for (genvar i = `DAG_GPR_LO; i <= `DAG_GPR_HI; i++) begin : g_gpr
      wire bus_hit = reg_wr && gpr_hit && (reg_addr[5:2] == 4'(i));
      wire x_hit   = x_fire && (x_tgt == 4'(i));
      wire y_hit   = y_fire && (y_tgt == 4'(i));
      wire s_hit   = s_fire && (s_tgt == 4'(i));
      assign gpr_d[i] = bus_hit ? reg_wdata :
                        x_hit   ? x_next :
                        y_hit   ? y_next :
                        s_hit   ? s_next :
                        gpr_q[i];
      always_ff @(posedge clk) begin
        if (reset) begin
          gpr_q[i] <= `DAG_GPR_RST;
        end else begin
          gpr_q[i] <= gpr_d[i];
        end
      end
    end
  endgenerate

  // Both bounds load in one longword write: end high, start low
  assign bounds_d = bounds_wr ? reg_wdata : bounds_q;
  assign ctrl_d   = ctrl_wr ? reg_wdata[1:0] : ctrl_q;

  assign rdata_d = !reg_rd                      ? 32'h0000_0000 :
                   (reg_addr == `DAG_OFF_CTRL)   ? {30'h0000_0000, ctrl_q} :
                   (reg_addr == `DAG_OFF_BOUNDS) ? bounds_q :
                   gpr_hit                       ? gpr_q[reg_addr[5:2]] :
                   (reg_addr == `DAG_OFF_X_ADDR) ? {16'h0000, x_addr_q} :
                   (reg_addr == `DAG_OFF_Y_ADDR) ? {16'h0000, y_addr_q} :
                   (reg_addr == `DAG_OFF_MAIN_ADDR) ? main_addr_q :
                   32'h0000_0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q   <= `DAG_CTRL_RST;
      bounds_q <= `DAG_BOUNDS_RST;
      rdata_q  <= `DAG_WORD_RST;
    end else begin
      ctrl_q   <= ctrl_d;
      bounds_q <= bounds_d;
      rdata_q  <= rdata_d;
    end
  end

  // Addresses issue from the pointer before its post-update; a single decrement issues the decremented value
  always_ff @(posedge clk) begin
    if (reset) begin
      x_addr_q    <= 16'h0000;
      y_addr_q    <= 16'h0000;
      main_addr_q <= `DAG_WORD_RST;
      x_req_q     <= 1'b0;
      y_req_q     <= 1'b0;
      main_req_q  <= 1'b0;
      main_long_q <= 1'b0;
    end else begin
      x_req_q    <= x_fire;
      y_req_q    <= y_fire;
      main_req_q <= s_fire;
      if (x_fire) begin
        x_addr_q <= x_ptr[15:0] & `DAG_ADDR_MASK;
      end
      if (y_fire) begin
        y_addr_q <= y_ptr[15:0] & `DAG_ADDR_MASK;
      end
      if (s_fire) begin
        main_addr_q <= s_access;
        main_long_q <= single_long;
      end
    end
  end

  assign reg_rdata               = rdata_q;
  assign x_memory_address_bus    = x_addr_q;
  assign y_memory_address_bus    = y_addr_q;
  assign main_memory_address_bus = main_addr_q;
  assign x_req                   = x_req_q;
  assign y_req                   = y_req_q;
  assign main_req                = main_req_q;
  assign main_long               = main_long_q;

  property p_x_source;
    @(posedge clk) disable iff (reset)
      x_fire |=> x_memory_address_bus == ($past(x_sel ? gpr_q[5][15:0] : gpr_q[4][15:0])
                                          & 16'hFFFE);
  endproperty
  a_x_source: assert property (p_x_source) else $error("X address not old R4/R5");

  property p_x_index;
    @(posedge clk) disable iff (reset)
      (x_fire && !reg_wr && x_sel && x_mode == dag_pkg::DAG_XY_IDX && !x_wrapped)
        |=> gpr_q[5] == $past(gpr_q[5]) + $past(gpr_q[8]);
  endproperty
  a_x_index: assert property (p_x_index) else $error("X index not R8");

  property p_x_inc;
    @(posedge clk) disable iff (reset)
      (x_fire && !reg_wr && x_mode == dag_pkg::DAG_XY_INC && !x_wrapped && !x_sel)
        |=> gpr_q[4] == $past(gpr_q[4]) + 32'h0000_0002;
  endproperty
  a_x_inc: assert property (p_x_inc) else $error("X increment not 2");

  property p_bit0;
    @(posedge clk) disable iff (reset)
      !x_memory_address_bus[0] && !y_memory_address_bus[0];
  endproperty
  a_bit0: assert property (p_bit0) else $error("Paired address bit 0 set");

  property p_y_upper;
    @(posedge clk) disable iff (reset)
      (y_fire && !reg_wr && !y_sel && y_mode != dag_pkg::DAG_XY_NOP)
        |=> gpr_q[6][31:16] == $past(gpr_q[6][31:16]);
  endproperty
  a_y_upper: assert property (p_y_upper) else $error("Y upper half changed");

  property p_s_post;
    @(posedge clk) disable iff (reset)
      (s_fire && single_mode != dag_pkg::DAG_S_DEC) |=> main_req
        && main_memory_address_bus == $past(s_ptr);
  endproperty
  a_s_post: assert property (p_s_post) else $error("Single access not old value");

  property p_s_pre;
    @(posedge clk) disable iff (reset)
      (s_fire && single_mode == dag_pkg::DAG_S_DEC) |=> main_memory_address_bus
        == $past(s_ptr) - ($past(single_long) ? 32'h0000_0004 : 32'h0000_0002);
  endproperty
  a_s_pre: assert property (p_s_pre) else $error("Single decrement wrong");

  property p_contend;
    @(posedge clk) disable iff (reset)
      xy_valid |-> !single_ready;
  endproperty
  a_contend: assert property (p_contend) else $error("Shared bus given during pair");

  property p_both_wrap;
    @(posedge clk) disable iff (reset)
      (ctrl_q == 2'h3 && x_fire && !reg_wr && !x_sel && x_mode == dag_pkg::DAG_XY_INC)
        |=> gpr_q[4] == $past(gpr_q[4]) + 32'h0000_0002;
  endproperty
  a_both_wrap: assert property (p_both_wrap) else $error("X wrapped with Y enabled");

  property p_wrap_load;
    @(posedge clk) disable iff (reset)
      (x_fire && x_wrap && x_mode != dag_pkg::DAG_XY_NOP && x_ptr[15:0] == bounds_q[31:16])
        |-> x_next[15:1] == bounds_q[15:1] && x_next[31:16] == x_ptr[31:16];
  endproperty
  a_wrap_load: assert property (p_wrap_load) else $error("Wrap did not load start");

  // Checked on the register itself, so a broken write-back path is caught too
  property p_y_wrap;
    @(posedge clk) disable iff (reset)
      (y_fire && !reg_wr && !y_sel && ctrl_q[`DAG_CTRL_Y_WRAP]
       && y_mode != dag_pkg::DAG_XY_NOP && gpr_q[6][15:0] == bounds_q[31:16])
        |-> y_wrapped ##1 gpr_q[6][15:1] == $past(bounds_q[15:1]);
  endproperty
  a_y_wrap: assert property (p_y_wrap) else $error("Y wrap did not load start");

  property p_s_nowrap;
    @(posedge clk) disable iff (reset)
      (s_fire && !reg_wr && single_sel == 2'h1 && single_mode == dag_pkg::DAG_S_INC)
        |=> gpr_q[3] == $past(gpr_q[3])
            + ($past(single_long) ? 32'h0000_0004 : 32'h0000_0002);
  endproperty
  a_s_nowrap: assert property (p_s_nowrap) else $error("Single pointer wrapped");

  property p_main_long;
    @(posedge clk) disable iff (reset)
      s_fire |=> main_req && main_long == $past(single_long);
  endproperty
  a_main_long: assert property (p_main_long) else $error("Transfer size not kept");

  property p_xy_req;
    @(posedge clk) disable iff (reset)
      (x_fire || y_fire) |=> (x_req == $past(x_fire)) && (y_req == $past(y_fire));
  endproperty
  a_xy_req: assert property (p_xy_req) else $error("Paired request not issued");

endmodule

// *** src/dag_xy_update.sv ***
// Post-update of one paired-transfer pointer, with optional wrap-around
`timescale 1ns/1ps
`include "dag_consts.svh"

module dag_xy_update (
  input  wire logic [31:0]          ptr,
  input  wire logic [31:0]          index,
  input  wire dag_pkg::dag_xy_mode_e mode,
  input  wire logic                 wrap_en,
  input  wire logic                 keep_upper,
  input  wire logic [31:0]          bounds,
  output logic      [31:0]          next_ptr,
  output logic                      wrapped
);

  logic [31:0] step;
  logic [31:0] sum;
  logic        end_hit;

  assign step    = (mode == dag_pkg::DAG_XY_INC) ? `DAG_STEP_WORD :
                   (mode == dag_pkg::DAG_XY_IDX) ? index : 32'h0000_0000;
  assign sum     = ptr + step;
  // Only the low half is compared, so a ring spans at most 64 kbytes
  assign end_hit = (ptr[15:0] == bounds[31:16]);
  assign wrapped = wrap_en && (mode != dag_pkg::DAG_XY_NOP) && end_hit;

  always_comb begin
    if (mode == dag_pkg::DAG_XY_NOP) begin
      next_ptr = ptr;
    end else if (wrapped) begin
      next_ptr = {ptr[31:16], bounds[15:1], ptr[0]};
    end else if (keep_upper) begin
      next_ptr = {ptr[31:16], sum[15:0]};
    end else begin
      // An index step over the end value is kept as summed
      next_ptr = sum;
    end
  end

endmodule

// *** tb/dag_mem_model.sv ***
// Behavioural X, Y and main memory side of the data address generator
`timescale 1ns/1ps

module dag_mem_model (
  input  wire logic        clk,
  input  wire logic        hold,
  input  wire logic        x_req,
  input  wire logic [15:0] x_addr,
  input  wire logic        y_req,
  input  wire logic [15:0] y_addr,
  input  wire logic        main_req,
  input  wire logic [31:0] main_addr,
  output logic             grant,
  output logic      [15:0] last_x,
  output logic      [15:0] last_y,
  output logic      [31:0] last_m
);
  // Shared bus is lent to other masters while hold is high
  assign grant = !hold;

  // Dedicated X and Y buses never stall, so a request is captured at once
  always_ff @(posedge clk) begin
    if (x_req)
      last_x <= x_addr;
    if (y_req)
      last_y <= y_addr;
    if (main_req)
      last_m <= main_addr;
  end
endmodule

// *** tb/dag_top_tb.sv ***
// Self-checking testbench of the data address generator
`timescale 1ns/1ps
`include "dag_consts.svh"

module dag_top_tb;
  logic                  clk, reset, reg_wr, reg_rd, xy_valid, x_en, x_sel, y_en, y_sel;
  logic                  single_valid, single_long, single_ready, hold, grant;
  logic                  x_req, y_req, main_req, main_long;
  logic [7:0]            reg_addr;
  logic [1:0]            single_sel;
  logic [15:0]           x_bus, y_bus, last_x, last_y;
  logic [31:0]           reg_wdata, reg_rdata, m_bus, last_m;
  dag_pkg::dag_xy_mode_e x_mode, y_mode;
  dag_pkg::dag_s_mode_e  single_mode;
  int                    mismatches, n_compared;

  dag_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xy_valid(xy_valid),
    .x_en(x_en), .x_sel(x_sel), .x_mode(x_mode), .y_en(y_en), .y_sel(y_sel),
    .y_mode(y_mode), .single_valid(single_valid), .single_sel(single_sel),
    .single_mode(single_mode), .single_long(single_long), .single_ready(single_ready),
    .core_bus_grant(grant), .x_memory_address_bus(x_bus), .x_req(x_req),
    .y_memory_address_bus(y_bus), .y_req(y_req), .main_memory_address_bus(m_bus),
    .main_req(main_req), .main_long(main_long));

  dag_mem_model mem (.clk(clk), .hold(hold), .x_req(x_req), .x_addr(x_bus),
    .y_req(y_req), .y_addr(y_bus), .main_req(main_req), .main_addr(m_bus),
    .grant(grant), .last_x(last_x), .last_y(last_y), .last_m(last_m));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic xy(input logic xe, xs, input dag_pkg::dag_xy_mode_e xm,
                    input logic ye, ys, input dag_pkg::dag_xy_mode_e ym,
                    input logic [15:0] ex, ey);
    @(posedge clk);
    xy_valid <= 1;
    x_en <= xe;
    x_sel <= xs;
    x_mode <= xm;
    y_en <= ye;
    y_sel <= ys;
    y_mode <= ym;
    @(posedge clk);
    xy_valid <= 0;
    #1;
    chk(32'(x_req), 32'(xe));
    chk(32'(y_req), 32'(ye));
    @(posedge clk);
    #1;
    if (xe)
      chk(32'(last_x), 32'(ex));
    if (ye)
      chk(32'(last_y), 32'(ey));
  endtask

  task automatic sg(input logic [1:0] s, input dag_pkg::dag_s_mode_e m,
                    input logic lng, input logic [31:0] ea);
    @(posedge clk);
    single_valid <= 1;
    single_sel <= s;
    single_mode <= m;
    single_long <= lng;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (single_ready === 1'b1)
        break;
    end
    @(posedge clk);
    single_valid <= 0;
    #1;
    chk(32'(main_req), 32'h0000_0001);
    chk(32'(main_long), 32'(lng));
    @(posedge clk);
    #1;
    chk(last_m, ea);
  endtask

  task automatic t_regs();
    rd(`DAG_OFF_CTRL, 32'h0000_0000);
    rd(`DAG_OFF_BOUNDS, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(`DAG_OFF_BOUNDS, 32'hE00C_E008);
    rd(`DAG_OFF_BOUNDS, 32'hE00C_E008);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000);
    wr(`DAG_OFF_X_ADDR, 32'h0000_1234);
    rd(`DAG_OFF_X_ADDR, 32'h0000_0000);
  endtask

  task automatic t_wrap();
    wr(`DAG_OFF_CTRL, 32'h0000_0001);
    wr(8'h10, 32'h1000_E008);
    for (int i = 0; i < 3; i++)
      xy(1, 0, dag_pkg::DAG_XY_INC, 0, 0, dag_pkg::DAG_XY_NOP, 16'hE008 + 16'(2 * i), 0);
    rd(8'h10, 32'h1000_E008);
    wr(8'h10, 32'h1000_E00C);
    xy(1, 0, dag_pkg::DAG_XY_NOP, 0, 0, dag_pkg::DAG_XY_NOP, 16'hE00C, 0);
    rd(8'h10, 32'h1000_E00C);
    wr(8'h14, 32'h0000_E00A);
    wr(8'h20, 32'h0000_0004);
    xy(1, 1, dag_pkg::DAG_XY_IDX, 0, 0, dag_pkg::DAG_XY_NOP, 16'hE00A, 0);
    rd(8'h14, 32'h0000_E00E);
    wr(`DAG_OFF_CTRL, 32'h0000_0003);
    wr(8'h10, 32'h1000_E00C);
    wr(8'h18, 32'h1234_E00C);
    xy(1, 0, dag_pkg::DAG_XY_INC, 1, 0, dag_pkg::DAG_XY_INC, 16'hE00C, 16'hE00C);
    rd(8'h10, 32'h1000_E00E);
    rd(8'h18, 32'h1234_E008);
  endtask

  task automatic t_y();
    wr(`DAG_OFF_CTRL, 32'h0000_0000);
    wr(8'h1C, 32'h5678_FFFE);
    xy(0, 0, dag_pkg::DAG_XY_NOP, 1, 1, dag_pkg::DAG_XY_INC, 0, 16'hFFFE);
    rd(8'h1C, 32'h5678_0000);
    wr(8'h24, 32'hFFFF_FFFE);
    wr(8'h18, 32'h0000_0100);
    xy(0, 0, dag_pkg::DAG_XY_NOP, 1, 0, dag_pkg::DAG_XY_IDX, 0, 16'h0100);
    rd(8'h18, 32'h0000_00FE);
  endtask

  task automatic t_single();
    wr(`DAG_OFF_CTRL, 32'h0000_0001);
    wr(8'h08, 32'h0000_0100);
    sg(0, dag_pkg::DAG_S_DEC, 1, 32'h0000_00FC);
    rd(8'h08, 32'h0000_00FC);
    sg(0, dag_pkg::DAG_S_DEC, 0, 32'h0000_00FA);
    wr(8'h0C, 32'h0000_E00C);
    sg(1, dag_pkg::DAG_S_INC, 0, 32'h0000_E00C);
    sg(1, dag_pkg::DAG_S_INC, 1, 32'h0000_E00E);
    rd(8'h0C, 32'h0000_E012);
    wr(8'h10, 32'h0000_0040);
    sg(2, dag_pkg::DAG_S_IDX, 1, 32'h0000_0040);
    rd(8'h10, 32'h0000_0044);
    wr(8'h14, 32'h0000_0080);
    sg(3, dag_pkg::DAG_S_NOP, 0, 32'h0000_0080);
    rd(8'h14, 32'h0000_0080);
  endtask

  // Refused while the shared bus is lent out and while xy_valid is high with no pointer enabled
  task automatic t_refuse();
    @(posedge clk);
    hold <= 1;
    single_valid <= 1;
    single_sel <= 0;
    single_mode <= dag_pkg::DAG_S_NOP;
    single_long <= 0;
    repeat (3) begin
      @(negedge clk);
      chk(32'(single_ready | main_req), 32'h0000_0000);
    end
    @(posedge clk);
    hold <= 0;
    xy_valid <= 1;
    x_en <= 0;
    y_en <= 0;
    @(negedge clk);
    chk(32'(single_ready), 32'h0000_0000);
    @(posedge clk);
    xy_valid <= 0;
    @(negedge clk);
    chk(32'(single_ready), 32'h0000_0001);
    @(posedge clk);
    single_valid <= 0;
    #1;
    chk(32'(main_req), 32'h0000_0001);
    chk(m_bus, 32'h0000_00FA);
  endtask

  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    {reset, reg_wr, reg_rd, xy_valid, x_en, x_sel, y_en, y_sel} = 8'h80;
    {single_valid, single_long, hold, single_sel} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    x_mode = dag_pkg::DAG_XY_NOP;
    y_mode = dag_pkg::DAG_XY_NOP;
    single_mode = dag_pkg::DAG_S_NOP;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    reset <= 0;
    t_regs();
    t_wrap();
    t_y();
    t_single();
    t_refuse();
    results();
  end
endmodule
